// >>> ir_host_port.sv
// Host serial port of the infrared protocol controller with APB registers.
`timescale 1ns/10ps
`default_nettype none
module ir_host_port (
	// Clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Host serial pins, handshakes active low
	input  wire logic        host_rx_in,
	output logic             host_tx_out,
	input  wire logic        host_ring_n,
	input  wire logic        host_dtr_n,
	input  wire logic        host_rts_n,
	input  wire logic        host_cd_n,
	output logic             dsr_n_out,
	output logic             cts_n_out,
	// Infrared side
	input  wire logic        ir_photodetect_in,
	output logic             ir_transmit_out,
	output logic             protocol_handler_active,
	// Interrupt
	output logic             irq
);
	import ir_host_port_pkg::*;

	// Two-stage synchronisers for every pin input.
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic [3:0] modem_prev_reg;

	// Each stage resets to its pin's idle level: serial and handshakes high,
	// photodetect low, so that no false pulse edge or modem change follows reset.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync1_reg <= 6'h1F;
			sync2_reg <= 6'h1F;
		end else if (clk_en) begin
			sync1_reg <= {ir_photodetect_in, host_cd_n, host_rts_n,
				host_dtr_n, host_ring_n, host_rx_in};
			sync2_reg <= sync1_reg;
		end
	end

	wire       rx_line = sync2_reg[0];
	wire [3:0] modem_n = sync2_reg[4:1];
	wire       rts_n_s = sync2_reg[3];
	wire       ir_s    = sync2_reg[5];

	// Registers.
	proto_mode_type       mode_reg;
	logic [15:0]          baud_reg;
	logic [INT_WIDTH-1:0] int_stat_reg;
	logic [INT_WIDTH-1:0] int_mask_reg;
	logic [7:0]           rx_data_reg;
	logic                 rx_full_reg;
	logic [7:0]           tx_byte_reg;
	logic                 tx_pend_reg;
	logic [15:0]          ir_count_reg;
	logic [15:0]          ir_width_reg;
	logic                 ir_prev_reg;
	logic [7:0]           ir_tx_cnt_reg;

	// APB decode: one wait state, answer registered with pready.
	wire apb_access = psel & penable & ~pready;
	wire apb_done   = psel & penable & pready;
	wire wr_done    = apb_done & pwrite;
	wire rd_done    = apb_done & ~pwrite;
	wire sel_ctrl   = (paddr == CTRL_OFFSET);
	wire sel_status = (paddr == STATUS_OFFSET);
	wire sel_istat  = (paddr == INT_STAT_OFFSET);
	wire sel_imask  = (paddr == INT_MASK_OFFSET);
	wire sel_txd    = (paddr == TX_DATA_OFFSET);
	wire sel_rxd    = (paddr == RX_DATA_OFFSET);
	wire sel_baud   = (paddr == BAUD_DIV_OFFSET);
	wire sel_irc    = (paddr == IR_COUNT_OFFSET);
	wire mapped     = sel_ctrl | sel_status | sel_istat | sel_imask |
		sel_txd | sel_rxd | sel_baud | sel_irc;

	// Serial engines.
	logic [7:0] rx_byte;
	logic       rx_valid;
	logic       rx_ferr;
	logic       tx_busy;
	logic       tx_done;
	logic       tx_line;

	// [RQ1] Host data receiver
	serial_rx u_rx (
		.core_clk  (core_clk),
		.rst       (rst),
		.clk_en    (clk_en),
		.bit_div   (baud_reg),
		.rxd       (rx_line),
		.data      (rx_byte),
		.valid     (rx_valid),
		.frame_err (rx_ferr)
	);

	// [RQ7] Start only while host requests data
	wire tx_start = tx_pend_reg & ~rts_n_s & ~tx_busy;

	// [RQ2] Host-bound transmitter
	serial_tx u_tx (
		.core_clk (core_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.bit_div  (baud_reg),
		.start    (tx_start),
		.data     (tx_byte_reg),
		.busy     (tx_busy),
		.done     (tx_done),
		.txd      (tx_line)
	);

	// [RQ9] Pulse width qualification
	wire ir_fall      = ir_prev_reg & ~ir_s;
	wire ir_width_ok  = (ir_width_reg >= 16'(IR_MIN_CYC)) &
		(ir_width_reg <= 16'(IR_MAX_CYC));
	wire ir_bit_ev    = ir_fall & ir_width_ok;
	wire ir_err_ev    = ir_fall & ~ir_width_ok;
	wire ir_width_sat = (ir_width_reg == 16'hFFFF);

	// [RQ3] Relay ring, terminal-ready, carrier changes
	wire modem_ev    = (modem_n != modem_prev_reg);
	wire overrun_ev  = rx_valid & rx_full_reg & ~(rd_done & sel_rxd);
	wire ir_send     = wr_done & sel_ctrl & pwdata[CTRL_IR_SEND];

	wire [INT_WIDTH-1:0] events = {overrun_ev, modem_ev, rx_ferr,
		ir_err_ev, ir_bit_ev, tx_done, rx_valid};
	wire [INT_WIDTH-1:0] w1c = (wr_done & sel_istat) ?
		pwdata[INT_WIDTH-1:0] : '0;
	// A new event in the clearing cycle survives the clear.
	wire [INT_WIDTH-1:0] int_stat_next = (int_stat_reg & ~w1c) | events;

	// Active-high views of the relayed handshake levels. Software forwards them
	// to the remote primary, so the block adds no framing of its own here.
	// [RQ3] Ring level relayed
	wire ring_present = ~modem_n[0];
	// [RQ5] Terminal-ready relayed as set-ready
	wire host_ready   = ~modem_n[1];
	wire rts_ready    = ~modem_n[2];
	// [RQ8] Carrier level relayed
	wire carrier_on   = ~modem_n[3];
	wire link_up      = (mode_reg == MODE_NRM);

	// Status word.
	wire [31:0] status_word = {22'h000000, ir_s, carrier_on, rts_ready,
		host_ready, ring_present, ~rx_full_reg, rx_full_reg, tx_pend_reg,
		tx_busy, link_up};

	wire [31:0] rd_mux =
		sel_ctrl   ? {30'h00000000, mode_reg} :
		sel_status ? status_word :
		sel_istat  ? {25'h0000000, int_stat_reg} :
		sel_imask  ? {25'h0000000, int_mask_reg} :
		sel_txd    ? {24'h000000, tx_byte_reg} :
		sel_rxd    ? {24'h000000, rx_data_reg} :
		sel_baud   ? {16'h0000, baud_reg} :
		sel_irc    ? {16'h0000, ir_count_reg} : 32'h00000000;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (clk_en) begin
			pready  <= apb_access;
			pslverr <= apb_access & ~mapped;
			if (apb_access)
				prdata <= pwrite ? 32'h00000000 : rd_mux;
		end
	end

	// Software registers.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_reg     <= MODE_NDM;
			baud_reg     <= BAUD_DIV_RESET;
			int_mask_reg <= INT_MASK_RESET;
			int_stat_reg <= '0;
		end else if (clk_en) begin
			int_stat_reg <= int_stat_next;
			if (wr_done & sel_ctrl)
				mode_reg <= proto_mode_type'(pwdata[CTRL_MODE_LSB +: 2]);
			if (wr_done & sel_baud)
				baud_reg <= pwdata[15:0];
			if (wr_done & sel_imask)
				int_mask_reg <= pwdata[INT_WIDTH-1:0];
		end
	end

	// Data holding registers.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_data_reg <= 8'h00;
			rx_full_reg <= 1'b0;
			tx_byte_reg <= 8'h00;
			tx_pend_reg <= 1'b0;
		end else if (clk_en) begin
			// A byte arriving with the read wins, so none is dropped silently.
			if (rx_valid) begin
				rx_data_reg <= rx_byte;
				rx_full_reg <= 1'b1;
			end else if (rd_done & sel_rxd) begin
				rx_full_reg <= 1'b0;
			end
			// Writes while a byte still waits are ignored.
			if (wr_done & sel_txd & ~tx_pend_reg) begin
				tx_byte_reg <= pwdata[7:0];
				tx_pend_reg <= 1'b1;
			end else if (tx_start) begin
				tx_pend_reg <= 1'b0;
			end
		end
	end

	// Infrared pulse measure and send.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ir_prev_reg    <= 1'b0;
			ir_width_reg   <= 16'h0000;
			ir_count_reg   <= 16'h0000;
			ir_tx_cnt_reg  <= 8'h00;
			modem_prev_reg <= 4'hF;
		end else if (clk_en) begin
			ir_prev_reg    <= ir_s;
			modem_prev_reg <= modem_n;
			if (!ir_s)
				ir_width_reg <= 16'h0000;
			else if (!ir_width_sat)
				ir_width_reg <= ir_width_reg + 16'h0001;
			if (ir_bit_ev)
				ir_count_reg <= ir_count_reg + 16'h0001;
			if (ir_send)
				ir_tx_cnt_reg <= 8'(IR_TX_CYC);
			else if (ir_tx_cnt_reg != 8'h00)
				ir_tx_cnt_reg <= ir_tx_cnt_reg - 8'h01;
		end
	end

	// Pin outputs, all registered.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			host_tx_out             <= 1'b1;
			dsr_n_out               <= 1'b1;
			cts_n_out               <= 1'b1;
			ir_transmit_out         <= 1'b0;
			protocol_handler_active <= 1'b0;
			irq                     <= 1'b0;
		end else if (clk_en) begin
			host_tx_out     <= tx_line;
			// [RQ4] Link established only in response mode
			dsr_n_out       <= (mode_reg != MODE_NRM);
			// [RQ6] Refuse while holding byte unread
			cts_n_out       <= rx_full_reg;
			ir_transmit_out <= (ir_tx_cnt_reg != 8'h00);
			// [RQ10] Active in discovery or response
			protocol_handler_active <= (mode_reg == MODE_DISCOVERY) |
				(mode_reg == MODE_NRM);
			irq             <= |(int_stat_next & int_mask_reg);
		end
	end
endmodule // ir_host_port
`default_nettype wire

// >>> ir_host_port_pkg.sv
// Constants, register map and types shared by the infrared host serial port.
// How it works
// [RQ1] Host serial data received on host input
// [RQ2] Serial data sent to host on output
// [RQ3] Ring input relayed, low means ring present
// [RQ4] Data-set-ready low only while link established
// [RQ5] Terminal-ready input relayed as remote set-ready
// [RQ6] Clear-to-send low only when byte accepted
// [RQ7] Host-bound data held while request-to-send high
// [RQ8] Carrier input relayed, low means carrier present
// [RQ9] Valid-width photodetect pulse counts one bit
// [RQ10] Activity output high in discovery or response
// [RQ11] Host drives reset from its own pin; the block takes reset only from its rst input, and no host pin drives it
// [RQ12] Frame: start, eight data LSB first, stop
package ir_host_port_pkg;

	// Register byte offsets, one aligned word each.
	localparam logic [7:0] CTRL_OFFSET      = 8'h00;
	localparam logic [7:0] STATUS_OFFSET    = 8'h04;
	localparam logic [7:0] INT_STAT_OFFSET  = 8'h08;
	localparam logic [7:0] INT_MASK_OFFSET  = 8'h0C;
	localparam logic [7:0] TX_DATA_OFFSET   = 8'h10;
	localparam logic [7:0] RX_DATA_OFFSET   = 8'h14;
	localparam logic [7:0] BAUD_DIV_OFFSET  = 8'h18;
	localparam logic [7:0] IR_COUNT_OFFSET  = 8'h1C;

	// Control fields.
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_IR_SEND    = 8;

	// Interrupt status bit positions.
	localparam int INT_RX_BYTE     = 0;
	localparam int INT_TX_DONE     = 1;
	localparam int INT_IR_BIT      = 2;
	localparam int INT_IR_WIDTH    = 3;
	localparam int INT_FRAME_ERR   = 4;
	localparam int INT_MODEM       = 5;
	localparam int INT_RX_OVERRUN  = 6;
	localparam int INT_WIDTH       = 7;

	// Reset values.
	localparam logic [15:0] BAUD_DIV_RESET = 16'h0A2C;
	localparam logic [6:0]  INT_MASK_RESET = 7'h00;

	// Timing, clock at 25 MHz.
	localparam int CLK_MHZ        = 25;
	localparam int IR_MIN_NS      = 1000;
	localparam int IR_MAX_NS      = 20000;
	localparam int IR_TX_NS       = 1600;
	localparam int IR_MIN_CYC     = (IR_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int IR_MAX_CYC     = (IR_MAX_NS * CLK_MHZ) / 1000;
	localparam int IR_TX_CYC      = (IR_TX_NS * CLK_MHZ + 999) / 1000;

	// Protocol handler modes.
	typedef enum logic [1:0] {
		MODE_NDM       = 2'b00,
		MODE_LOW_POWER = 2'b01,
		MODE_DISCOVERY = 2'b10,
		MODE_NRM       = 2'b11
	} proto_mode_type;

endpackage

// >>> serial_rx.sv
// Asynchronous serial receiver, one start, eight data LSB first, one stop.
`timescale 1ns/10ps
`default_nettype none
module serial_rx (
	// Clock and control
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic [15:0] bit_div,
	// Synchronised line
	input  wire logic        rxd,
	// Received byte
	output logic [7:0]       data,
	output logic             valid,
	output logic             frame_err
);
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_type;

	rx_state_type state_reg;
	logic [15:0]  cnt_reg;
	logic [2:0]   bit_reg;
	logic [7:0]   shift_reg;
	wire          tick = (cnt_reg == 16'h0000);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= RX_IDLE;
			cnt_reg   <= 16'h0000;
			bit_reg   <= 3'h0;
			shift_reg <= 8'h00;
			data      <= 8'h00;
			valid     <= 1'b0;
			frame_err <= 1'b0;
		end else if (clk_en) begin
			valid     <= 1'b0;
			frame_err <= 1'b0;
			if (!tick)
				cnt_reg <= cnt_reg - 16'h0001;
			unique case (state_reg)
				RX_IDLE: if (!rxd) begin
					// Land on mid-bit so later samples sit in bit centres.
					cnt_reg   <= {1'b0, bit_div[15:1]};
					state_reg <= RX_START;
				end
				RX_START: if (tick) begin
					if (rxd) begin
						state_reg <= RX_IDLE;
					end else begin
						cnt_reg   <= bit_div;
						bit_reg   <= 3'h0;
						state_reg <= RX_DATA;
					end
				end
				// [RQ12] LSB first data
				RX_DATA: if (tick) begin
					shift_reg <= {rxd, shift_reg[7:1]};
					cnt_reg   <= bit_div;
					bit_reg   <= bit_reg + 3'h1;
					if (bit_reg == 3'h7)
						state_reg <= RX_STOP;
				end
				RX_STOP: if (tick) begin
					state_reg <= RX_IDLE;
					if (rxd) begin
						data  <= shift_reg;
						valid <= 1'b1;
					end else begin
						frame_err <= 1'b1;
					end
				end
			endcase
		end
	end
endmodule // serial_rx
`default_nettype wire

// >>> serial_tx.sv
// Asynchronous serial transmitter, one start, eight data LSB first, one stop.
`timescale 1ns/10ps
`default_nettype none
module serial_tx (
	// Clock and control
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic [15:0] bit_div,
	// Byte to send
	input  wire logic        start,
	input  wire logic [7:0]  data,
	output logic             busy,
	output logic             done,
	// Line
	output logic             txd
);
	logic [15:0] cnt_reg;
	logic [3:0]  bit_reg;
	logic [9:0]  frame_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_reg   <= 16'h0000;
			bit_reg   <= 4'h0;
			frame_reg <= 10'h3FF;
			busy      <= 1'b0;
			done      <= 1'b0;
			txd       <= 1'b1;
		end else if (clk_en) begin
			done <= 1'b0;
			if (!busy) begin
				if (start) begin
					// [RQ12] Start, data LSB first, stop
					frame_reg <= {1'b1, data, 1'b0};
					txd       <= 1'b0;
					cnt_reg   <= bit_div;
					bit_reg   <= 4'h0;
					busy      <= 1'b1;
				end
			end else if (cnt_reg != 16'h0000) begin
				cnt_reg <= cnt_reg - 16'h0001;
			end else if (bit_reg == 4'h9) begin
				busy <= 1'b0;
				done <= 1'b1;
				txd  <= 1'b1;
			end else begin
				bit_reg <= bit_reg + 4'h1;
				txd     <= frame_reg[bit_reg + 4'h1];
				cnt_reg <= bit_div;
			end
		end
	end
endmodule // serial_tx
`default_nettype wire

// >>> ir_host_port_chk.sv
// Concurrent checks on the infrared host port pins.
`timescale 1ns/10ps
`default_nettype none
module ir_host_port_chk
	import ir_host_port_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic host_tx_out,
	input wire logic dsr_n_out,
	input wire logic cts_n_out,
	input wire logic ir_transmit_out,
	input wire logic protocol_handler_active,
	input wire logic irq
);
	import ir_host_port_pkg::*;
	logic [7:0] ir_cnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	always_ff @(posedge core_clk)
		ir_cnt <= (rst || !ir_transmit_out) ? 8'h00 : ir_cnt + 8'h01;
	sequence s_setup_access;
		psel && !penable ##1 psel && penable;
	endsequence
	a_ready_after_access: assert property (s_setup_access |=> pready)
		else $error("bus answer late");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("answer outside access");
	a_ready_single: assert property (pready |=> !pready)
		else $error("answer too long");
	a_slverr_with_ready: assert property (pslverr |-> pready)
		else $error("error without answer");
	// The reset itself is the cause here, so this one is never disabled.
	a_reset_state: assert property (disable iff (1'b0) rst |=> host_tx_out && dsr_n_out
		&& cts_n_out && !irq && !pready && !protocol_handler_active && !ir_transmit_out)
		else $error("bad state after reset");
	a_idle_no_link: assert property (!protocol_handler_active |-> dsr_n_out)
		else $error("link shown while idle");
	a_ir_pulse_width: assert property ($fell(ir_transmit_out) |-> ir_cnt == 8'(IR_TX_CYC))
		else $error("ir pulse width wrong");
	a_ir_pulse_max: assert property (ir_transmit_out |-> ir_cnt < 8'(IR_TX_CYC))
		else $error("ir pulse too long");
endmodule // ir_host_port_chk
bind ir_host_port ir_host_port_chk i_ir_host_port_chk (
	.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .host_tx_out(host_tx_out), .dsr_n_out(dsr_n_out),
	.cts_n_out(cts_n_out), .ir_transmit_out(ir_transmit_out),
	.protocol_handler_active(protocol_handler_active), .irq(irq)
);
`default_nettype wire

// >>> host_uart_model.sv
// Host serial port model: sends frames and collects received ones.
`timescale 1ns/10ps
`default_nettype none
module host_uart_model #(
	parameter int BIT_CYC = 16
) (
	// Clock
	input wire logic core_clk,
	// Serial pins
	input wire logic host_tx_out,
	input wire logic cts_n_out,
	output logic host_rx_in
);
	logic [7:0] rx_byte;
	int rx_count = 0;
	initial host_rx_in = 1'b1;
	// send only when cleared; a low stop bit breaks the frame
	task automatic send_byte(input logic [7:0] b, input logic stop);
		logic [9:0] frame;
		frame = {stop, b, 1'b0};
		@(posedge core_clk);
		while (cts_n_out !== 1'b0) @(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			host_rx_in <= frame[i];
			repeat (BIT_CYC) @(posedge core_clk);
		end
		// One idle bit time, so a broken frame never runs into the next one.
		host_rx_in <= 1'b1;
		repeat (BIT_CYC) @(posedge core_clk);
	endtask
	always begin
		@(negedge host_tx_out);
		repeat (BIT_CYC / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge core_clk);
			rx_byte[i] = host_tx_out;
		end
		repeat (BIT_CYC) @(posedge core_clk);
		rx_count++;
	end
endmodule // host_uart_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the infrared host serial port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import ir_host_port_pkg::*;
	localparam int BIT = 16;
	logic core_clk = 1'b0;
	logic rst, psel, penable, pwrite, pready, pslverr, err_seen;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, c0;
	logic host_rx_in, host_tx_out, ring_n, dtr_n, rts_n, cd_n;
	logic dsr_n, cts_n, ir_in, ir_out, active, irq, held;
	int num_errors = 0;
	int tests_run = 0;
	int ir_high = 0;
	int w[4] = '{IR_MIN_CYC, IR_MAX_CYC, IR_MIN_CYC - 1, IR_MAX_CYC + 1};
	logic [31:0] eb[4] = '{32'h4, 32'h4, 32'h8, 32'h8};
	always #20 core_clk = ~core_clk;
	ir_host_port i_ir_host_port (
		.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.host_rx_in(host_rx_in), .host_tx_out(host_tx_out), .host_ring_n(ring_n),
		.host_dtr_n(dtr_n), .host_rts_n(rts_n), .host_cd_n(cd_n), .dsr_n_out(dsr_n),
		.cts_n_out(cts_n), .ir_photodetect_in(ir_in), .ir_transmit_out(ir_out),
		.protocol_handler_active(active), .irq(irq)
	);
	host_uart_model #(.BIT_CYC(BIT)) i_host_uart_model (.core_clk(core_clk),
		.host_tx_out(host_tx_out), .cts_n_out(cts_n), .host_rx_in(host_rx_in));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One idle edge first, so back-to-back calls never drive a pin twice in one step.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Wait for the answer however long it takes; only the watchdog ends a hang.
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		q = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(q, e);
	endtask
	task automatic end_of_test();
		$display("Counts: %0d compares, %0d mismatches", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ring_n, dtr_n, rts_n, cd_n} = 4'hF;
		ir_in = 1'b0;
		rst = 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		repeat (5) @(posedge core_clk);
		rd(BAUD_DIV_OFFSET, {16'h0000, BAUD_DIV_RESET});
		rd(INT_MASK_OFFSET, 32'h0);
		rd(8'h20, 32'h0);
		check({31'h0, err_seen}, 32'h1);
		wr(BAUD_DIV_OFFSET, 32'(BIT - 1));
		wr(INT_STAT_OFFSET, 32'h7F);
		$display("reset and map test done");
		for (int m = 0; m < 4; m++) begin
			wr(CTRL_OFFSET, 32'(m));
			repeat (2) @(posedge core_clk);
			check({31'h0, active}, 32'(m / 2));
			check({31'h0, dsr_n}, 32'(m != 3));
		end
		$display("mode test done");
		i_host_uart_model.send_byte(8'hA5, 1'b1);
		repeat (4) @(posedge core_clk);
		check({31'h0, cts_n}, 32'h1);
		rd(RX_DATA_OFFSET, 32'hA5);
		repeat (2) @(posedge core_clk);
		check({31'h0, cts_n}, 32'h0);
		rd(INT_STAT_OFFSET, 32'h1);
		wr(INT_STAT_OFFSET, 32'h7F);
		i_host_uart_model.send_byte(8'h5A, 1'b0);
		repeat (4) @(posedge core_clk);
		rd(INT_STAT_OFFSET, 32'h10);
		check({31'h0, cts_n}, 32'h0);
		$display("host to device test done");
		held = 1'b1;
		wr(TX_DATA_OFFSET, 32'h3C);
		repeat (40) begin
			@(posedge core_clk);
			held &= host_tx_out;
		end
		check({31'h0, held}, 32'h1);
		rts_n <= 1'b0;
		for (int n = 0; n < 400 && i_host_uart_model.rx_count == 0; n++) @(posedge core_clk);
		check({24'h0, i_host_uart_model.rx_byte}, 32'h3C);
		repeat (BIT) @(posedge core_clk);
		wr(INT_STAT_OFFSET, 32'h7F);
		{ring_n, dtr_n, cd_n} <= 3'b000;
		repeat (5) @(posedge core_clk);
		rd(STATUS_OFFSET, 32'h1F1);
		check({31'h0, irq}, 32'h0);
		wr(INT_MASK_OFFSET, 32'h20);
		repeat (2) @(posedge core_clk);
		check({31'h0, irq}, 32'h1);
		wr(INT_STAT_OFFSET, 32'h20);
		repeat (2) @(posedge core_clk);
		check({31'h0, irq}, 32'h0);
		$display("modem and interrupt test done");
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, IR_COUNT_OFFSET, 32'h0);
			c0 = q;
			ir_in <= 1'b1;
			repeat (w[i]) @(posedge core_clk);
			ir_in <= 1'b0;
			repeat (8) @(posedge core_clk);
			rd(IR_COUNT_OFFSET, c0 + 32'(i < 2));
			rd(INT_STAT_OFFSET, eb[i]);
			wr(INT_STAT_OFFSET, 32'h7F);
		end
		wr(CTRL_OFFSET, 32'h103);
		repeat (60) begin
			@(posedge core_clk);
			ir_high += ir_out;
		end
		check(32'(ir_high), 32'(IR_TX_CYC));
		$display("infrared test done");
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
